// [lubi_cfg.svh]
`ifndef LUBI_CFG_SVH
`define LUBI_CFG_SVH

// Register word addresses
`define LUBI_ADDR_CTRL 4'h0
`define LUBI_ADDR_CMD 4'h1
`define LUBI_ADDR_STATUS 4'h2
`define LUBI_ADDR_RXDATA 4'h3
`define LUBI_ADDR_TXDATA 4'h4
`define LUBI_ADDR_DIVLO 4'h5
`define LUBI_ADDR_DIVHI 4'h6
`define LUBI_ADDR_DIVWORD 4'h7

// Control register fields
`define LUBI_CTRL_RXIRQEN 0
`define LUBI_CTRL_TXIRQEN 1
`define LUBI_CTRL_MODE_LSB 2
`define LUBI_CTRL_MODE_MSB 3
`define LUBI_CTRL_STARTSTOP 4
`define LUBI_CTRL_OUTCLK 5
`define LUBI_CTRL_DIRCLK 6
`define LUBI_CTRL_SLAVE 7
`define LUBI_CTRL_PAREN 8
`define LUBI_CTRL_TXENA 9
`define LUBI_CTRL_RXENA 10
`define LUBI_CTRL_WIDTH 11

// Command register fields (write only, self clearing)
`define LUBI_CMD_REARM 0
`define LUBI_CMD_SOFTCLR 1
`define LUBI_CMD_ERRCLR 2

// Status register fields
`define LUBI_STAT_RXFULL 0
`define LUBI_STAT_PARERR 1
`define LUBI_STAT_OVRUN 2
`define LUBI_STAT_FRMERR 3
`define LUBI_STAT_TXEMPTY 4
`define LUBI_STAT_RXVALID 5
`define LUBI_STAT_RXIRQ 6
`define LUBI_STAT_TXIRQ 7

// Reset values
`define LUBI_CTRL_RST 11'h000
`define LUBI_DIV_RST 15'h0000
`define LUBI_TXEMPTY_RST 1'b1

`endif

// [lubi_pkg.sv]
package lubi_pkg;

    typedef enum logic [1:0] {
        LUBI_MODE_ASYNC = 2'b00,
        LUBI_MODE_MULTI = 2'b01,
        LUBI_MODE_SYNC = 2'b10,
        LUBI_MODE_LIN = 2'b11
    } lubi_mode_t;

    // Encoded as {outside select, direct select}
    typedef enum logic [1:0] {
        LUBI_SRC_INTERNAL = 2'b00,
        LUBI_SRC_UNUSED = 2'b01,
        LUBI_SRC_PIN_DIV = 2'b10,
        LUBI_SRC_PIN_DIRECT = 2'b11
    } lubi_clk_src_t;

    typedef logic [14:0] lubi_count_t;

endpackage

// [lubi_top.sv]
`timescale 1ns/100ps
`include "lubi_cfg.svh"

// What this block does
// R1: Receive word lands at first stop bit; unframed sync mode after last data bit.
// R2: Receive interrupt when full or any error flag set and receive interrupt enable is 1.
// R3: Word captured alongside an error is marked invalid for software.
// R4: Parity error never set in multiprocessor or LIN mode.
// R5: Overrun only when a new word completes while the full flag is still set.
// R6: Transmit empty set when holding word moves to shifter; interrupt if enabled.
// R7: Transmit empty is read only; only a holding register write clears it.
// R8: Transmit empty resets to 1, so enabling its interrupt fires at once.
// R9: No parity in LIN mode nor in sync mode without start/stop framing.
// R10: Two select bits pick internal divided, pin divided or pin direct clock.
// R11: Two independent 15-bit reload counters for transmit and receive, same reload.
// R12: Each counter divides its source by reload value plus one.
// R13: Reload 0 stops the counter; software uses at least 4 for async.
// R14: Serial clock falls floor((reload+1)/2) source cycles into each period.
// R15: Software keeps synchronous bit rate at or below machine clock over five.
// R16: The external clock pin is synchronised to the internal clock before use.
// R17: Writing the divisor starts the counters; byte and word writes accepted.
// R18: Reading the divisor returns the live transmit counter value.
// R19: Rearm command reloads both counters next cycle without clearing first.
// R20: Async start bit falling edge restarts the receive counter.
// R21: Reset clears reload value and both counters to zero, counters stopped.
// R22: Soft clear zeroes both counters, keeps reload, counters restart at once.
// R23: Reading receive data clears full flag; error clear command clears errors.
// R24: Counters count down to zero then reload on the next source clock.
module lubi_top
    import lubi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [15:0] regRdData,
    input wire logic serialClockPin,
    output logic txSerialClock,
    output logic rxSerialClock,
    output logic txBaudTick,
    output logic rxBaudTick,
    input wire logic rxStopSeen,
    input wire logic rxLastDataBit,
    input wire logic [7:0] rxWord,
    input wire logic rxParityBad,
    input wire logic rxStopBad,
    input wire logic rxStartFall,
    input wire logic txShiftIdle,
    output logic txShiftLoad,
    output logic [7:0] txShiftWord,
    output logic parityActive,
    output logic [1:0] frameMode,
    output logic rxIrq,
    output logic txIrq
);

    // Serial clock level: high for the first half of the period
    function automatic logic clkLevel(input lubi_count_t cnt, input lubi_count_t rel);
        logic [15:0] elapsed;
        logic [15:0] half;
        elapsed = {1'b0, rel} - {1'b0, cnt};
        half = ({1'b0, rel} + 16'h0001) >> 1;
        clkLevel = (rel != 15'h0000) && (elapsed < half); // R14
    endfunction

    // One source tick of a reload counter
    function automatic lubi_count_t cntStep(input lubi_count_t cnt, input lubi_count_t rel,
                                            input logic srcTick);
        cntStep = cnt;
        if (srcTick && rel != 15'h0000) // R13
        begin
            if (cnt == 15'h0000)
            begin
                cntStep = rel; // R24
            end
            else
            begin
                cntStep = cnt - 15'h0001; // R12
            end
        end
    endfunction

    // Period start marker of a reload counter
    function automatic logic cntWrap(input lubi_count_t cnt, input lubi_count_t rel,
                                     input logic srcTick);
        cntWrap = srcTick && (rel != 15'h0000) && (cnt == 15'h0000);
    endfunction

    // Register state
    logic [10:0] ctrl_r;
    logic [10:0] ctrl_nxt;
    lubi_count_t reload_r;
    lubi_count_t reload_nxt;
    lubi_count_t txCnt_r;
    lubi_count_t txCnt_nxt;
    lubi_count_t rxCnt_r;
    lubi_count_t rxCnt_nxt;
    logic [15:0] rdData_r;
    logic [15:0] rdData_nxt;

    // Pin synchroniser and edge memory
    logic pinMeta_r;
    logic pinSync_r;
    logic pinPrev_r;

    // Serial clock outputs
    logic txClk_r;
    logic txClk_nxt;
    logic rxClk_r;
    logic rxClk_nxt;
    logic txTick_r;
    logic txTick_nxt;
    logic rxTick_r;
    logic rxTick_nxt;

    // Flag state
    logic rxFull_r;
    logic rxFull_nxt;
    logic parErr_r;
    logic parErr_nxt;
    logic overrun_r;
    logic overrun_nxt;
    logic frmErr_r;
    logic frmErr_nxt;
    logic txEmpty_r;
    logic txEmpty_nxt;
    logic [7:0] rxHold_r;
    logic [7:0] rxHold_nxt;
    logic [7:0] txHold_r;
    logic [7:0] txHold_nxt;
    logic [7:0] txShift_r;
    logic [7:0] txShift_nxt;
    logic txLoad_r;
    logic txLoad_nxt;
    logic parAct_r;
    logic parAct_nxt;

    // Decoded controls
    lubi_mode_t mode;
    lubi_clk_src_t clkSrc;
    logic startStop;
    logic unframedSync;
    logic wrCtrl;
    logic wrCmd;
    logic wrTx;
    logic wrDivLo;
    logic wrDivHi;
    logic wrDivWord;
    logic divWrite;
    logic rdRx;
    logic rearm;
    logic softClr;
    logic errClr;
    logic pinRise;
    logic srcTick;
    logic txWrap;
    logic rxWrap;
    logic rxCapture;
    logic rxRestart;
    logic txStart;
    logic [15:0] status;

    always_comb
    begin
        mode = lubi_mode_t'(ctrl_r[`LUBI_CTRL_MODE_MSB:`LUBI_CTRL_MODE_LSB]);
        clkSrc = lubi_clk_src_t'({ctrl_r[`LUBI_CTRL_OUTCLK], ctrl_r[`LUBI_CTRL_DIRCLK]});
        startStop = ctrl_r[`LUBI_CTRL_STARTSTOP];
        unframedSync = (mode == LUBI_MODE_SYNC) && !startStop;
        wrCtrl = regWrStb && (regAddr == `LUBI_ADDR_CTRL);
        wrCmd = regWrStb && (regAddr == `LUBI_ADDR_CMD);
        wrTx = regWrStb && (regAddr == `LUBI_ADDR_TXDATA);
        wrDivLo = regWrStb && (regAddr == `LUBI_ADDR_DIVLO);
        wrDivHi = regWrStb && (regAddr == `LUBI_ADDR_DIVHI);
        wrDivWord = regWrStb && (regAddr == `LUBI_ADDR_DIVWORD);
        divWrite = wrDivLo || wrDivHi || wrDivWord;
        rdRx = regRdStb && (regAddr == `LUBI_ADDR_RXDATA);
        rearm = wrCmd && regWrData[`LUBI_CMD_REARM];
        softClr = wrCmd && regWrData[`LUBI_CMD_SOFTCLR];
        errClr = wrCmd && regWrData[`LUBI_CMD_ERRCLR];
        // Edge taken from the second synchroniser stage only
        pinRise = pinSync_r && !pinPrev_r; // R16
    end

    // Control and divisor registers
    always_comb
    begin
        ctrl_nxt = ctrl_r;
        reload_nxt = reload_r;
        if (wrCtrl)
        begin
            ctrl_nxt = regWrData[`LUBI_CTRL_WIDTH-1:0];
        end
        if (wrDivLo) // R17
        begin
            reload_nxt = {reload_r[14:8], regWrData[7:0]};
        end
        if (wrDivHi) // R17
        begin
            reload_nxt = {regWrData[6:0], reload_r[7:0]};
        end
        if (wrDivWord) // R17
        begin
            reload_nxt = regWrData[14:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            ctrl_r <= `LUBI_CTRL_RST;
            reload_r <= `LUBI_DIV_RST; // R21
        end
        else
        begin
            ctrl_r <= ctrl_nxt;
            reload_r <= reload_nxt;
        end
    end

    // Reload counters and serial clock generation
    always_comb
    begin
        case (clkSrc) // R10
            LUBI_SRC_INTERNAL: srcTick = 1'b1;
            LUBI_SRC_PIN_DIV: srcTick = pinRise;
            LUBI_SRC_PIN_DIRECT: srcTick = pinRise;
            default: srcTick = 1'b1;
        endcase
        txWrap = cntWrap(txCnt_r, reload_r, srcTick);
        rxWrap = cntWrap(rxCnt_r, reload_r, srcTick);
        rxRestart = rxStartFall && (mode != LUBI_MODE_SYNC); // R20
        // Two separate counters sharing one reload value
        txCnt_nxt = cntStep(txCnt_r, reload_r, srcTick); // R11
        rxCnt_nxt = cntStep(rxCnt_r, reload_r, srcTick); // R11
        if (softClr)
        begin
            txCnt_nxt = 15'h0000; // R22
            rxCnt_nxt = 15'h0000; // R22
        end
        else if (divWrite)
        begin
            txCnt_nxt = reload_nxt; // R17
            rxCnt_nxt = reload_nxt; // R17
        end
        else if (rearm)
        begin
            txCnt_nxt = reload_r; // R19
            rxCnt_nxt = reload_r; // R19
        end
        else if (rxRestart)
        begin
            rxCnt_nxt = reload_r; // R20
        end
        if (clkSrc == LUBI_SRC_PIN_DIRECT) // R10
        begin
            txClk_nxt = pinSync_r; // R16
            rxClk_nxt = pinSync_r;
            txTick_nxt = pinRise;
            rxTick_nxt = pinRise;
        end
        else
        begin
            txClk_nxt = clkLevel(txCnt_nxt, reload_r); // R14
            rxClk_nxt = clkLevel(rxCnt_nxt, reload_r); // R14
            txTick_nxt = txWrap && !softClr;
            rxTick_nxt = rxWrap && !softClr;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            txCnt_r <= 15'h0000; // R21
            rxCnt_r <= 15'h0000; // R21
            pinMeta_r <= 1'b0;
            pinSync_r <= 1'b0;
            pinPrev_r <= 1'b0;
            txClk_r <= 1'b0;
            rxClk_r <= 1'b0;
            txTick_r <= 1'b0;
            rxTick_r <= 1'b0;
        end
        else
        begin
            txCnt_r <= txCnt_nxt;
            rxCnt_r <= rxCnt_nxt;
            pinMeta_r <= serialClockPin; // R16
            pinSync_r <= pinMeta_r;
            pinPrev_r <= pinSync_r;
            txClk_r <= txClk_nxt;
            rxClk_r <= rxClk_nxt;
            txTick_r <= txTick_nxt;
            rxTick_r <= rxTick_nxt;
        end
    end

    // Receive and transmit flags
    always_comb
    begin
        rxCapture = ctrl_r[`LUBI_CTRL_RXENA] && (unframedSync ? rxLastDataBit : rxStopSeen); // R1
        parAct_nxt = ctrl_nxt[`LUBI_CTRL_PAREN]; // R9
        if (ctrl_nxt[`LUBI_CTRL_MODE_MSB:`LUBI_CTRL_MODE_LSB] == LUBI_MODE_LIN)
        begin
            parAct_nxt = 1'b0; // R9
        end
        if (ctrl_nxt[`LUBI_CTRL_MODE_MSB:`LUBI_CTRL_MODE_LSB] == LUBI_MODE_MULTI)
        begin
            parAct_nxt = 1'b0; // R4
        end
        if (ctrl_nxt[`LUBI_CTRL_MODE_MSB:`LUBI_CTRL_MODE_LSB] == LUBI_MODE_SYNC
            && !ctrl_nxt[`LUBI_CTRL_STARTSTOP])
        begin
            parAct_nxt = 1'b0; // R9
        end
        rxHold_nxt = rxCapture ? rxWord : rxHold_r; // R1
        // A completing word wins over a read in the same cycle
        rxFull_nxt = rxCapture ? 1'b1 : (rdRx ? 1'b0 : rxFull_r); // R23
        overrun_nxt = overrun_r;
        parErr_nxt = parErr_r;
        frmErr_nxt = frmErr_r;
        if (errClr)
        begin
            overrun_nxt = 1'b0; // R23
            parErr_nxt = 1'b0; // R23
            frmErr_nxt = 1'b0; // R23
        end
        if (rxCapture && rxFull_r && !rdRx)
        begin
            overrun_nxt = 1'b1; // R5
        end
        if (rxCapture && parAct_r && rxParityBad)
        begin
            parErr_nxt = 1'b1; // R4
        end
        if (rxCapture && rxStopBad && !unframedSync)
        begin
            frmErr_nxt = 1'b1;
        end
        txStart = !txEmpty_r && txShiftIdle && txTick_r && ctrl_r[`LUBI_CTRL_TXENA];
        txHold_nxt = wrTx ? regWrData[7:0] : txHold_r;
        txShift_nxt = txStart ? txHold_r : txShift_r;
        txLoad_nxt = txStart;
        // A write in the load cycle refills the holder, so the flag stays clear
        if (wrTx)
        begin
            txEmpty_nxt = 1'b0; // R7
        end
        else if (txStart)
        begin
            txEmpty_nxt = 1'b1; // R6
        end
        else
        begin
            txEmpty_nxt = txEmpty_r;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rxFull_r <= 1'b0;
            parErr_r <= 1'b0;
            overrun_r <= 1'b0;
            frmErr_r <= 1'b0;
            txEmpty_r <= `LUBI_TXEMPTY_RST; // R8
            rxHold_r <= 8'h00;
            txHold_r <= 8'h00;
            txShift_r <= 8'h00;
            txLoad_r <= 1'b0;
            parAct_r <= 1'b0;
        end
        else
        begin
            rxFull_r <= rxFull_nxt;
            parErr_r <= parErr_nxt;
            overrun_r <= overrun_nxt;
            frmErr_r <= frmErr_nxt;
            txEmpty_r <= txEmpty_nxt;
            rxHold_r <= rxHold_nxt;
            txHold_r <= txHold_nxt;
            txShift_r <= txShift_nxt;
            txLoad_r <= txLoad_nxt;
            parAct_r <= parAct_nxt;
        end
    end

    // Read path, data one cycle after the strobe
    always_comb
    begin
        status = 16'h0000;
        status[`LUBI_STAT_RXFULL] = rxFull_r;
        status[`LUBI_STAT_PARERR] = parErr_r;
        status[`LUBI_STAT_OVRUN] = overrun_r;
        status[`LUBI_STAT_FRMERR] = frmErr_r;
        status[`LUBI_STAT_TXEMPTY] = txEmpty_r; // R7
        status[`LUBI_STAT_RXVALID] = rxFull_r && !(parErr_r || overrun_r || frmErr_r); // R3
        status[`LUBI_STAT_RXIRQ] = rxIrq;
        status[`LUBI_STAT_TXIRQ] = txIrq;
        rdData_nxt = 16'h0000;
        if (regRdStb)
        begin
            case (regAddr)
                `LUBI_ADDR_CTRL: rdData_nxt = {5'h00, ctrl_r};
                `LUBI_ADDR_STATUS: rdData_nxt = status;
                `LUBI_ADDR_RXDATA: rdData_nxt = {8'h00, rxHold_r};
                `LUBI_ADDR_DIVLO: rdData_nxt = {8'h00, txCnt_r[7:0]}; // R18
                `LUBI_ADDR_DIVHI: rdData_nxt = {9'h000, txCnt_r[14:8]}; // R18
                `LUBI_ADDR_DIVWORD: rdData_nxt = {1'b0, txCnt_r}; // R18
                default: rdData_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            rdData_r <= 16'h0000;
        end
        else
        begin
            rdData_r <= rdData_nxt;
        end
    end

    always_comb
    begin
        rxIrq = ctrl_r[`LUBI_CTRL_RXIRQEN] && (rxFull_r || parErr_r || overrun_r || frmErr_r); // R2
        txIrq = ctrl_r[`LUBI_CTRL_TXIRQEN] && txEmpty_r; // R6 R8
        regRdData = rdData_r;
        txSerialClock = txClk_r;
        rxSerialClock = rxClk_r;
        txBaudTick = txTick_r;
        rxBaudTick = rxTick_r;
        txShiftLoad = txLoad_r;
        txShiftWord = txShift_r;
        parityActive = parAct_r;
        frameMode = ctrl_r[`LUBI_CTRL_MODE_MSB:`LUBI_CTRL_MODE_LSB];
    end

endmodule

// [lubi_top_properties.sv]
`timescale 1ns/100ps
module lubi_top_properties
    import lubi_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [15:0] regRdData,
    input wire logic txBaudTick,
    input wire logic rxStopSeen,
    input wire logic rxLastDataBit,
    input wire logic txShiftIdle,
    input wire logic txShiftLoad,
    input wire logic [7:0] txShiftWord,
    input wire logic parityActive,
    input wire logic [1:0] frameMode,
    input wire logic rxIrq,
    input wire logic txIrq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_rx_irq_cause: assert property (
        $rose(rxIrq) |-> $past(rxStopSeen || rxLastDataBit || regWrStb))
        else $error("rx irq rose without capture or write");
    a_rx_irq_clear: assert property (
        $fell(rxIrq) |-> $past(regRdStb || regWrStb))
        else $error("rx irq fell without register access");
    a_tx_load_cause: assert property (
        txShiftLoad |-> $past(txBaudTick && txShiftIdle))
        else $error("shifter load without tick and idle");
    a_tx_irq_clear: assert property (
        $fell(txIrq) |-> $past(regWrStb))
        else $error("tx irq fell without a write");
    a_word_hold: assert property (
        !txShiftLoad |-> $stable(txShiftWord))
        else $error("shifter word moved without load");
    a_read_idle: assert property (
        !$past(regRdStb) |-> regRdData == 16'h0000)
        else $error("read data outside answer cycle");
    a_lin_parity: assert property (
        frameMode == LUBI_MODE_LIN |-> !parityActive)
        else $error("parity active in LIN mode");
    a_multi_parity: assert property (
        frameMode == LUBI_MODE_MULTI |-> !parityActive)
        else $error("parity active in multiprocessor mode");

    c_load: cover property (txShiftLoad);
    c_rx_irq: cover property ($rose(rxIrq));
    c_tick_period: cover property (txBaudTick ##5 txBaudTick);
endmodule

bind lubi_top lubi_top_properties i_lubi_top_properties (.clk(clk), .rst_b(rst_b),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .txBaudTick(txBaudTick), .rxStopSeen(rxStopSeen), .rxLastDataBit(rxLastDataBit),
    .txShiftIdle(txShiftIdle), .txShiftLoad(txShiftLoad), .txShiftWord(txShiftWord),
    .parityActive(parityActive), .frameMode(frameMode), .rxIrq(rxIrq), .txIrq(txIrq));

// [lubi_peer.sv]
`timescale 1ns/100ps
module lubi_peer (
    input wire logic clk,
    input wire logic txShiftLoad,
    output logic rxStopSeen,
    output logic rxLastDataBit,
    output logic [7:0] rxWord,
    output logic rxParityBad,
    output logic rxStopBad,
    output logic rxStartFall,
    output logic txShiftIdle
);
    int busyCnt = 0;

    // Shifter stays busy for a frame after every load
    always @(posedge clk)
    begin
        if (txShiftLoad === 1'b1)
            busyCnt <= 12;
        else if (busyCnt > 0)
            busyCnt <= busyCnt - 1;
    end
    assign txShiftIdle = (busyCnt == 0);

    initial
    begin
        rxStopSeen = 1'b0;
        rxLastDataBit = 1'b0;
        rxWord = 8'h00;
        rxParityBad = 1'b0;
        rxStopBad = 1'b0;
        rxStartFall = 1'b0;
    end

    // Start edge, some bit times, then one capture pulse
    task automatic rxFrame(input logic [7:0] w, input logic parBad, input logic stopBad,
        input logic lastBit);
        @(posedge clk);
        rxStartFall <= 1'b1;
        @(posedge clk);
        rxStartFall <= 1'b0;
        repeat (4) @(posedge clk);
        rxWord <= w;
        rxParityBad <= parBad;
        rxStopBad <= stopBad;
        rxLastDataBit <= lastBit;
        rxStopSeen <= !lastBit;
        @(posedge clk);
        rxLastDataBit <= 1'b0;
        rxStopSeen <= 1'b0;
        // Released lines show the inverse, never the held value
        rxWord <= ~w;
        rxParityBad <= ~parBad;
        rxStopBad <= ~stopBad;
    endtask
endmodule

// [lubi_top_test.sv]
`timescale 1ns/100ps
`include "lubi_cfg.svh"
module lubi_top_test;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrStb = 1'b0;
    logic regRdStb = 1'b0;
    logic serialClockPin = 1'b0;
    logic [15:0] regRdData;
    logic txSerialClock, rxSerialClock, txBaudTick, rxBaudTick, txShiftLoad;
    logic rxStopSeen, rxLastDataBit, rxParityBad, rxStopBad, rxStartFall, txShiftIdle;
    logic parityActive, rxIrq, txIrq;
    logic [7:0] rxWord, txShiftWord;
    logic [1:0] frameMode;
    logic [2:0] pinDiv = 3'h0;
    logic chkPend = 1'b0;
    logic [15:0] rdExp = 16'h0000;
    logic [15:0] chkExp = 16'h0000;
    logic [15:0] srcCtrl [3] = '{16'h0000, 16'h0020, 16'h00E8};
    int srcTicks [3] = '{16, 2, 10};
    int srcHigh [3] = '{32, 32, 40};
    int error_cnt = 0;
    int compares = 0;
    int n, t, r, h, g;
    logic par;

    always #20 clk = ~clk;

    // Pin clock at an eighth of clk keeps sync slave within the rate limit
    always @(posedge clk)
    begin
        pinDiv <= pinDiv + 3'h1;
        serialClockPin <= pinDiv[2];
    end

    lubi_top i_lubi_top (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
        .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
        .serialClockPin(serialClockPin), .txSerialClock(txSerialClock),
        .rxSerialClock(rxSerialClock), .txBaudTick(txBaudTick), .rxBaudTick(rxBaudTick),
        .rxStopSeen(rxStopSeen), .rxLastDataBit(rxLastDataBit), .rxWord(rxWord),
        .rxParityBad(rxParityBad), .rxStopBad(rxStopBad), .rxStartFall(rxStartFall),
        .txShiftIdle(txShiftIdle), .txShiftLoad(txShiftLoad), .txShiftWord(txShiftWord),
        .parityActive(parityActive), .frameMode(frameMode), .rxIrq(rxIrq), .txIrq(txIrq));

    lubi_peer i_lubi_peer (.clk(clk), .txShiftLoad(txShiftLoad), .rxStopSeen(rxStopSeen),
        .rxLastDataBit(rxLastDataBit), .rxWord(rxWord), .rxParityBad(rxParityBad),
        .rxStopBad(rxStopBad), .rxStartFall(rxStartFall), .txShiftIdle(txShiftIdle));

    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task results;
        if (error_cnt == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task busWr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrStb <= 1'b1;
        regRdStb <= 1'b0;
    endtask

    task busRd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        rdExp <= e;
        regRdStb <= 1'b1;
        regWrStb <= 1'b0;
    endtask

    task idle(input int c);
        @(posedge clk);
        regWrStb <= 1'b0;
        regRdStb <= 1'b0;
        repeat (c) @(posedge clk);
    endtask

    task waitLoad(input logic [7:0] w);
        for (n = 0; n < 100 && txShiftLoad !== 1'b1; n++)
            @(posedge clk);
        if (n == 100)
        begin
            error_cnt++;
            results();
        end
        check("txShiftWord", {8'h00, txShiftWord}, {8'h00, w});
        check("txIrq", {15'h0, txIrq}, 16'h0001);
    endtask

    task countTicks;
        t = 0;
        r = 0;
        h = 0;
        g = 0;
        repeat (80)
        begin
            @(posedge clk);
            t += (txBaudTick === 1'b1);
            r += (rxBaudTick === 1'b1);
            h += (txSerialClock === 1'b1);
            g += (rxSerialClock === 1'b1);
        end
    endtask

    // Read answers are compared in the cycle after the strobe is taken
    always @(posedge clk)
    begin
        if (chkPend)
            check("regRdData", regRdData, chkExp);
        chkPend <= regRdStb;
        chkExp <= rdExp;
    end

    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        busRd(`LUBI_ADDR_STATUS, 16'h0010);
        busRd(`LUBI_ADDR_DIVWORD, 16'h0000);
        busRd(4'hF, 16'h0000);
        busRd(`LUBI_ADDR_TXDATA, 16'h0000);
        busWr(`LUBI_ADDR_CTRL, 16'h0002);
        idle(1);
        check("txIrq", {15'h0, txIrq}, 16'h0001);
        busWr(`LUBI_ADDR_DIVWORD, 16'h0004);
        for (n = 0; n < 6; n++)
            busRd(`LUBI_ADDR_DIVWORD, (n == 5) ? 16'h0004 : 16'(4 - n));
        busWr(`LUBI_ADDR_CMD, 16'h0001);
        busRd(`LUBI_ADDR_DIVWORD, 16'h0004);
        busRd(`LUBI_ADDR_DIVWORD, 16'h0003);
        busWr(`LUBI_ADDR_CMD, 16'h0002);
        busRd(`LUBI_ADDR_DIVWORD, 16'h0000);
        busRd(`LUBI_ADDR_DIVWORD, 16'h0004);
        busWr(`LUBI_ADDR_DIVLO, 16'h0034);
        busRd(`LUBI_ADDR_DIVWORD, 16'h0034);
        busWr(`LUBI_ADDR_DIVHI, 16'h0012);
        busRd(`LUBI_ADDR_DIVLO, 16'h0034);
        busRd(`LUBI_ADDR_DIVHI, 16'h0012);
        busWr(`LUBI_ADDR_DIVWORD, 16'h0000);
        idle(3);
        countTicks();
        check("txBaudTick", 16'(t), 16'h0000);
        check("txSerialClock", 16'(h), 16'h0000);
        busWr(`LUBI_ADDR_DIVWORD, 16'h0004);
        for (n = 0; n < 3; n++)
        begin
            busWr(`LUBI_ADDR_CTRL, srcCtrl[n]);
            idle(20);
            countTicks();
            check("txBaudTick", 16'(t), 16'(srcTicks[n]));
            check("rxBaudTick", 16'(r), 16'(srcTicks[n]));
            check("txSerialClock", 16'(h), 16'(srcHigh[n]));
            check("rxSerialClock", 16'(g), 16'(srcHigh[n]));
        end
        for (n = 0; n < 4; n++)
        begin
            par = (n == 0 || n == 2);
            busWr(`LUBI_ADDR_CTRL, 16'h0511 | 16'(n << 2));
            idle(1);
            check("parityActive", {15'h0, parityActive}, {15'h0, par});
            i_lubi_peer.rxFrame(8'hA5 ^ 8'(n), 1'b1, 1'b0, 1'b0);
            idle(1);
            check("rxIrq", {15'h0, rxIrq}, 16'h0001);
            busRd(`LUBI_ADDR_STATUS, par ? 16'h0053 : 16'h0071);
            busRd(`LUBI_ADDR_RXDATA, 16'h00A5 ^ 16'(n));
            busWr(`LUBI_ADDR_CMD, 16'h0004);
            busRd(`LUBI_ADDR_STATUS, 16'h0010);
            idle(1);
        end
        busWr(`LUBI_ADDR_CTRL, 16'h0509);
        idle(1);
        check("parityActive", {15'h0, parityActive}, 16'h0000);
        i_lubi_peer.rxFrame(8'h3C, 1'b1, 1'b1, 1'b0);
        busRd(`LUBI_ADDR_STATUS, 16'h0010);
        idle(0);
        i_lubi_peer.rxFrame(8'h3C, 1'b1, 1'b1, 1'b1);
        busRd(`LUBI_ADDR_STATUS, 16'h0071);
        busRd(`LUBI_ADDR_RXDATA, 16'h003C);
        busWr(`LUBI_ADDR_CTRL, 16'h0002);
        busWr(`LUBI_ADDR_TXDATA, 16'h005A);
        busWr(`LUBI_ADDR_STATUS, 16'hFFFF);
        busRd(`LUBI_ADDR_STATUS, 16'h0000);
        idle(1);
        check("txIrq", {15'h0, txIrq}, 16'h0000);
        busWr(`LUBI_ADDR_CTRL, 16'h0202);
        idle(0);
        waitLoad(8'h5A);
        busRd(`LUBI_ADDR_STATUS, 16'h0090);
        busWr(`LUBI_ADDR_TXDATA, 16'h00C3);
        idle(0);
        waitLoad(8'hC3);
        busWr(`LUBI_ADDR_CTRL, 16'h0501);
        idle(0);
        i_lubi_peer.rxFrame(8'h11, 1'b0, 1'b0, 1'b0);
        @(posedge clk);
        check("rxBaudTick", {15'h0, rxBaudTick}, 16'h0001);
        i_lubi_peer.rxFrame(8'h22, 1'b0, 1'b1, 1'b0);
        busRd(`LUBI_ADDR_STATUS, 16'h005D);
        busWr(`LUBI_ADDR_CMD, 16'h0004);
        busRd(`LUBI_ADDR_STATUS, 16'h0071);
        idle(1);
        rst_b <= 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        busRd(`LUBI_ADDR_STATUS, 16'h0010);
        busRd(`LUBI_ADDR_DIVWORD, 16'h0000);
        idle(2);
        results();
    end
endmodule
